// ===== src/ctm_defines.svh
/*
  Offsets, field positions, reset values and divider counts of the compact timer.
  Assumes it is included by bare name from the top module.
*/
// Contract
// - Fine low-byte write goes to buffer; high-byte write commits high bits and buffer.
// - High-byte read returns high bits and captures low byte into buffer for later.
// - Ten-bit up-counter advances once per active tick.
// - Coarse comparator sees counter bits 9..7; fine comparator sees all ten.
// - Coarse 1..7 gives 128..896 tick periods; coarse 0 gives 1024.
// - Run rise clears and starts counter; run fall stops and keeps the count.
// - Compare mode: run rise restores pin to start level.
// - Hold freezes counter without powering down; release resumes from held value.
// - Tick select: sys/4, sys, high/16, high/64, sub, sub, ext rise, ext fall.
// - Counter auto-clears on overflow or selected comparator match, raising a request; the code raises none when a fine value of zero clears it.
// - Software cannot load the counter; only run rise or an auto-clear zeroes it.
// - Mode select: 00 compare, 01 undefined, 10 PWM, 11 timer.
// - Compare mode fine match: 00 keep, 01 low, 10 high, 11 toggle.
// - PWM action: 00 inactive, 01 active, 10 waveform, 11 undefined.
// - Requested level equal to start level gives no visible change.
// - Clear select 0: coarse match clears; coarse zero clears by overflow.
// - Two output pins, each the same waveform or its inverse.
// - Unused high-byte bits read zero; bits 1..0 hold bits 9..8.
// - Start level: initial level in compare mode, active level in PWM.
// - Invert bit flips the pin waveform except in timer and undefined modes.
// - Swap 0: coarse period, fine duty; swap 1 exchanges roles.
// - Clear select 1: fine match clears, no coarse flag; ignored in PWM.
`ifndef CTM_DEFINES_SVH
`define CTM_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CTM_OFS_CTRL_CLOCK_RUN 4'h0
`define CTM_OFS_CTRL_MODE_PIN  4'h1
`define CTM_OFS_COUNT_LOW      4'h2
`define CTM_OFS_COUNT_HIGH     4'h3
`define CTM_OFS_FINE_LOW       4'h4
`define CTM_OFS_FINE_HIGH      4'h5
`define CTM_OFS_MATCH_FLAGS    4'h6
`define CTM_OFS_PIN_PAIR       4'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTM_C0_HOLD      7
`define CTM_C0_TICK_HI   6
`define CTM_C0_TICK_LO   4
`define CTM_C0_RUN       3
`define CTM_C0_COARSE_HI 2
`define CTM_C1_MODE_HI   7
`define CTM_C1_MODE_LO   6
`define CTM_C1_ACT_HI    5
`define CTM_C1_ACT_LO    4
`define CTM_C1_START     3
`define CTM_C1_INVERT    2
`define CTM_C1_SWAP      1
`define CTM_C1_CLRSEL    0
`define CTM_FLG_FINE     0
`define CTM_FLG_COARSE   1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define CTM_RST_BYTE     8'h00
`define CTM_RST_COUNT    10'h000
`define CTM_COUNT_MAX    10'h3ff
`define CTM_FULL_PERIOD  11'h400
`define CTM_SYS_DIV_LAST 2'h3
`define CTM_H16_LAST     4'hf
`define CTM_H64_LAST     6'h3f

`endif

// ===== src/ctm_pkg.sv
/*
  Types shared by the compact timer: mode and tick encodings, bus request, state.
  Assumes the defines header sits beside it in src/.
*/
package ctm_pkg;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CTM_MODE_CMP   = 2'b00,
    CTM_MODE_UNDEF = 2'b01,
    CTM_MODE_PWM   = 2'b10,
    CTM_MODE_TMR   = 2'b11
  } ctm_mode_t;

  typedef enum logic [2:0] {
    CTM_TICK_SYS4  = 3'h0,
    CTM_TICK_SYS   = 3'h1,
    CTM_TICK_H16   = 3'h2,
    CTM_TICK_H64   = 3'h3,
    CTM_TICK_SUB_A = 3'h4,
    CTM_TICK_SUB_B = 3'h5,
    CTM_TICK_RISE  = 3'h6,
    CTM_TICK_FALL  = 3'h7
  } ctm_tick_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ctm_bus_req_t;

  typedef struct packed {
    logic       wave_out_a;
    logic       wave_out_b;
    logic       fine_match_flag;
    logic       coarse_match_flag;
  } ctm_pins_t;

  typedef struct packed {
    logic [7:0] ctrl_clock_run;
    logic [7:0] ctrl_mode_pin;
    logic [1:0] pin_pair;
    logic [9:0] count;
    logic [9:0] fine;
    logic [7:0] byte_buf;
    logic [7:0] rdata;
    logic       fine_flag;
    logic       coarse_flag;
    logic       run_prev;
    logic       pin_lvl;
    logic       wave_a;
    logic       wave_b;
    logic [1:0] ext_sy;
    logic       ext_prev;
    logic [1:0] hi_sy;
    logic       hi_prev;
    logic [1:0] sub_sy;
    logic       sub_prev;
    logic [1:0] sys_div;
    logic [5:0] hi_div;
  } ctm_state_t;

endpackage

// ===== src/ctm_top.sv
/*
  Compact 10-bit timer with coarse and fine comparators, compare output, timer and PWM modes.
  Assumes a byte register port on clk, and tick pins far slower than half of clk.
*/
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "ctm_defines.svh"

module ctm_top
  import ctm_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Register port
  input  wire ctm_bus_req_t bus_req,
  output logic [7:0]        bus_rdata,
  // Tick pins
  input  wire logic         ext_tick_pin,
  input  wire logic         hi_clk_pin,
  input  wire logic         sub_clk_pin,
  // Waveform pins and request flags
  output ctm_pins_t         pins
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when the next count lands on the compare value; value 0 means overflow
  function automatic logic ctm_hit(input logic [9:0] cnt, input logic [9:0] val);
    logic [9:0] nx;
    nx = cnt + 10'h001;
    return nx == val;
  endfunction

  // Coarse value as a length in ticks; zero stands for the full range
  function automatic logic [10:0] ctm_coarse_len(input logic [2:0] c);
    return (c == 3'h0) ? `CTM_FULL_PERIOD : {1'b0, c, 7'h00};
  endfunction

  ctm_state_t st;
  ctm_state_t next_st;

  // ----------------------------------------------------------------
  // Decoded control fields
  // ----------------------------------------------------------------
  logic       hold;
  logic       run;
  logic [2:0] coarse;
  ctm_mode_t  mode;
  logic [1:0] act;
  logic       start_lvl;
  logic       invert;
  logic       swap;
  logic       clrsel;
  ctm_tick_t  tick_sel;

  assign hold      = st.ctrl_clock_run[`CTM_C0_HOLD];
  assign run       = st.ctrl_clock_run[`CTM_C0_RUN];
  assign coarse    = st.ctrl_clock_run[`CTM_C0_COARSE_HI:0];
  assign tick_sel  = ctm_tick_t'(st.ctrl_clock_run[`CTM_C0_TICK_HI:`CTM_C0_TICK_LO]);
  assign mode      = ctm_mode_t'(st.ctrl_mode_pin[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
  assign act       = st.ctrl_mode_pin[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
  assign start_lvl = st.ctrl_mode_pin[`CTM_C1_START];
  assign invert    = st.ctrl_mode_pin[`CTM_C1_INVERT];
  assign swap      = st.ctrl_mode_pin[`CTM_C1_SWAP];
  assign clrsel    = st.ctrl_mode_pin[`CTM_C1_CLRSEL];

  // ----------------------------------------------------------------
  // Tick sources
  // ----------------------------------------------------------------
  logic ext_rise;
  logic ext_fall;
  logic hi_edge;
  logic sub_edge;
  logic tick;

  // Edge detectors read only the second synchroniser stage
  assign ext_rise = st.ext_sy[1] & ~st.ext_prev;
  assign ext_fall = ~st.ext_sy[1] & st.ext_prev;
  assign hi_edge  = st.hi_sy[1] & ~st.hi_prev;
  assign sub_edge = st.sub_sy[1] & ~st.sub_prev;

  // Tick source multiplexer
  always_comb begin
    unique case (tick_sel)
      CTM_TICK_SYS4:  tick = (st.sys_div == `CTM_SYS_DIV_LAST);
      CTM_TICK_SYS:   tick = 1'b1;
      CTM_TICK_H16:   tick = hi_edge & (st.hi_div[3:0] == `CTM_H16_LAST);
      CTM_TICK_H64:   tick = hi_edge & (st.hi_div == `CTM_H64_LAST);
      CTM_TICK_SUB_A: tick = sub_edge;
      CTM_TICK_SUB_B: tick = sub_edge;
      CTM_TICK_RISE:  tick = ext_rise;
      CTM_TICK_FALL:  tick = ext_fall;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter and comparators
  // ----------------------------------------------------------------
  logic        run_rise;
  logic        active;
  logic [9:0]  coarse10;
  logic        coarse_hit;
  logic        fine_hit;
  logic        fine_any;
  logic        clr;
  logic        coarse_set;
  logic [10:0] duty;
  logic [10:0] period;
  logic        pwm_on;

  assign run_rise = run & ~st.run_prev;
  // Hold and off both freeze the count; a run rise overrides the tick
  assign active   = run & ~hold & tick & ~run_rise;
  assign coarse10 = {coarse, 7'h00};
  // Coarse zero lands on 0 after 3ff, so overflow counts as its match
  assign coarse_hit = active & ctm_hit(st.count, coarse10);
  assign fine_any   = active & ctm_hit(st.count, st.fine);
  // A fine value of zero is a plain overflow and raises no fine request
  assign fine_hit   = fine_any & (st.fine != 10'h000);

  // Clear condition: period comparator in PWM, clear select otherwise
  always_comb begin
    if (mode == CTM_MODE_PWM) begin
      clr = swap ? fine_any : coarse_hit;
    end else begin
      clr = clrsel ? fine_any : coarse_hit;
    end
  end

  assign coarse_set = coarse_hit & ((mode == CTM_MODE_PWM) | ~clrsel);

  // Edge-aligned PWM: active while count is under the duty length
  assign period = swap ? ((st.fine == 10'h000) ? `CTM_FULL_PERIOD : {1'b0, st.fine}) : ctm_coarse_len(coarse);
  assign duty   = swap ? ctm_coarse_len(coarse) : {1'b0, st.fine};
  // Duty at or above the period keeps the output active all period
  assign pwm_on = ({1'b0, st.count} < duty) | (duty >= period);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic        sel_c0;
  logic        sel_c1;
  logic        sel_cl;
  logic        sel_ch;
  logic        sel_fl;
  logic        sel_fh;
  logic        sel_flg;
  logic        sel_pair;
  logic        wave;

  assign sel_c0   = (bus_req.addr == `CTM_OFS_CTRL_CLOCK_RUN);
  assign sel_c1   = (bus_req.addr == `CTM_OFS_CTRL_MODE_PIN);
  assign sel_cl   = (bus_req.addr == `CTM_OFS_COUNT_LOW);
  assign sel_ch   = (bus_req.addr == `CTM_OFS_COUNT_HIGH);
  assign sel_fl   = (bus_req.addr == `CTM_OFS_FINE_LOW);
  assign sel_fh   = (bus_req.addr == `CTM_OFS_FINE_HIGH);
  assign sel_flg  = (bus_req.addr == `CTM_OFS_MATCH_FLAGS);
  assign sel_pair = (bus_req.addr == `CTM_OFS_PIN_PAIR);

  // Timer and undefined modes hold the waveform low; the pin pair can still invert it
  assign wave = ((mode == CTM_MODE_CMP) | (mode == CTM_MODE_PWM)) ? (st.pin_lvl ^ invert) : 1'b0;

  always_comb begin
    next_st = st;

    // Synchronisers: first stage feeds only the second
    next_st.ext_sy   = {st.ext_sy[0], ext_tick_pin};
    next_st.ext_prev = st.ext_sy[1];
    next_st.hi_sy    = {st.hi_sy[0], hi_clk_pin};
    next_st.hi_prev  = st.hi_sy[1];
    next_st.sub_sy   = {st.sub_sy[0], sub_clk_pin};
    next_st.sub_prev = st.sub_sy[1];
    next_st.sys_div  = st.sys_div + 2'h1;
    next_st.hi_div   = hi_edge ? (st.hi_div + 6'h01) : st.hi_div;
    next_st.run_prev = run;

    // Counter: only a run rise or the timer's own tick changes it
    if (run_rise) begin
      next_st.count = `CTM_RST_COUNT;
    end else if (active) begin
      next_st.count = clr ? `CTM_RST_COUNT : (st.count + 10'h001);
    end

    // Sticky request flags; a set in the clearing cycle wins
    next_st.fine_flag   = fine_hit |
                          (st.fine_flag & ~(bus_req.wr & sel_flg & bus_req.wdata[`CTM_FLG_FINE]));
    next_st.coarse_flag = coarse_set |
                          (st.coarse_flag & ~(bus_req.wr & sel_flg & bus_req.wdata[`CTM_FLG_COARSE]));

    // Pin level per mode
    unique case (mode)
      CTM_MODE_CMP: begin
        if (run_rise) begin
          next_st.pin_lvl = start_lvl;
        end else if (fine_hit) begin
          unique case (act)
            2'b00: next_st.pin_lvl = st.pin_lvl;
            2'b01: next_st.pin_lvl = 1'b0;
            2'b10: next_st.pin_lvl = 1'b1;
            2'b11: next_st.pin_lvl = ~st.pin_lvl;
          endcase
        end
      end
      CTM_MODE_PWM: begin
        unique case (act)
          2'b00: next_st.pin_lvl = ~start_lvl;
          2'b01: next_st.pin_lvl = start_lvl;
          2'b10: next_st.pin_lvl = pwm_on ? start_lvl : ~start_lvl;
          2'b11: next_st.pin_lvl = st.pin_lvl;
        endcase
      end
      CTM_MODE_UNDEF: next_st.pin_lvl = st.pin_lvl;
      CTM_MODE_TMR:   next_st.pin_lvl = st.pin_lvl;
    endcase

    // Pin pair: each pin is the waveform or its inverse
    next_st.wave_a = wave ^ st.pin_pair[0];
    next_st.wave_b = wave ^ st.pin_pair[1];

    // Register writes; the count pair has no write path
    if (bus_req.wr) begin
      if (sel_c0) begin
        next_st.ctrl_clock_run = bus_req.wdata;
      end
      if (sel_c1) begin
        next_st.ctrl_mode_pin = bus_req.wdata;
      end
      if (sel_fl) begin
        next_st.byte_buf = bus_req.wdata;
      end
      if (sel_fh) begin
        next_st.fine = {bus_req.wdata[1:0], st.byte_buf};
      end
      if (sel_pair) begin
        next_st.pin_pair = bus_req.wdata[1:0];
      end
    end

    // Register reads; data stand for exactly one cycle
    next_st.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (1'b1)
        sel_c0:   next_st.rdata = st.ctrl_clock_run;
        sel_c1:   next_st.rdata = st.ctrl_mode_pin;
        sel_cl:   next_st.rdata = st.byte_buf;
        sel_ch: begin
          next_st.rdata    = {6'h00, st.count[9:8]};
          next_st.byte_buf = st.count[7:0];
        end
        sel_fl:   next_st.rdata = st.byte_buf;
        sel_fh: begin
          next_st.rdata    = {6'h00, st.fine[9:8]};
          next_st.byte_buf = st.fine[7:0];
        end
        sel_flg:  next_st.rdata = {6'h00, st.coarse_flag, st.fine_flag};
        sel_pair: next_st.rdata = {6'h00, st.pin_pair};
        default:  next_st.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Power-on reset clears every register and pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata              = st.rdata;
  assign pins.wave_out_a        = st.wave_a;
  assign pins.wave_out_b        = st.wave_b;
  assign pins.fine_match_flag   = st.fine_flag;
  assign pins.coarse_match_flag = st.coarse_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fine_low_buffered: assert property (@(posedge clk) disable iff (!nrst)
    (bus_req.wr && sel_fl) |=> (st.fine == $past(st.fine)) && (st.byte_buf == $past(bus_req.wdata)))
    else $error("fine low write changed compare value");

  chk_fine_high_commit: assert property (@(posedge clk) disable iff (!nrst)
    (bus_req.wr && sel_fh) |=> st.fine == {$past(bus_req.wdata[1:0]), $past(st.byte_buf)})
    else $error("fine high write did not commit buffer");

  chk_count_high_capture: assert property (@(posedge clk) disable iff (!nrst)
    (bus_req.rd && sel_ch) ##1 (bus_req.rd && sel_cl) |=> st.rdata == $past(st.count[7:0], 2))
    else $error("count low read missed captured byte");

  chk_high_upper_zero: assert property (@(posedge clk) disable iff (!nrst)
    (bus_req.rd && (sel_ch || sel_fh)) |=> st.rdata[7:2] == 6'h00)
    else $error("high byte upper bits not zero");

  chk_count_step: assert property (@(posedge clk) disable iff (!nrst)
    (active && !clr) |=> st.count == 10'($past(st.count) + 10'h001))
    else $error("counter did not step by one");

  chk_run_rise_zero: assert property (@(posedge clk) disable iff (!nrst)
    $rose(run) |=> (st.count == 10'h000) ##1 (st.count <= 10'h001))
    else $error("run rise did not clear counter");

  chk_frozen_count: assert property (@(posedge clk) disable iff (!nrst)
    (hold || !run) && !run_rise |=> $stable(st.count))
    else $error("count moved while held or off");

  chk_coarse_period: assert property (@(posedge clk) disable iff (!nrst)
    (active && coarse_hit && clr) |=> st.count == 10'h000 && $past(st.count) == 10'(coarse10 - 10'h001))
    else $error("coarse period wrong");

  chk_no_coarse_flag: assert property (@(posedge clk) disable iff (!nrst)
    (mode != CTM_MODE_PWM && clrsel && !st.coarse_flag) |=> !st.coarse_flag)
    else $error("coarse flag raised with fine clear");

  chk_fine_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    fine_hit |=> st.fine_flag)
    else $error("fine match flag not set");

  chk_cmp_init_level: assert property (@(posedge clk) disable iff (!nrst)
    (mode == CTM_MODE_CMP && run_rise) |=> st.pin_lvl == $past(start_lvl))
    else $error("pin not restored to start level");

  chk_pin_pair: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (st.wave_a ^ st.wave_b) == ^$past(st.pin_pair))
    else $error("pin pair relation broken");

endmodule // ctm_top

// ===== verif/ctm_tick_src.sv
/*
  Far-side model of the tick pins: free high and sub clocks, an external tick on demand.
  Assumes clk is the timer's system clock; the external tick pin changes just after its rising edge.
*/
`timescale 1ns/10ps

module ctm_tick_src (
  // System clock
  input  wire logic clk,
  // Tick pins
  output logic      ext_tick_pin,
  output logic      hi_clk_pin,
  output logic      sub_clk_pin
);
  // ----------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------
  // Free running, phase unrelated to clk; both well below clk/4
  initial begin
    ext_tick_pin = 1'b0;
    hi_clk_pin   = 1'b0;
    sub_clk_pin  = 1'b0;
  end
  always #32 hi_clk_pin = ~hi_clk_pin;
  always #100 sub_clk_pin = ~sub_clk_pin;

  // High stands four clocks and low five, so the synchroniser sees every edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk) ext_tick_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_tick_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // ctm_tick_src

// ===== verif/testbench.sv
/*
  Self-checking bench for the compact timer: registers, counting, ticks, compare and PWM output.
  Assumes ctm_top from src/ and the tick pin model beside it.
*/
`timescale 1ns/10ps

module testbench;
  import ctm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  ctm_bus_req_t bus_req = '0;
  logic [7:0]   bus_rdata;
  logic         ext_tick_pin, hi_clk_pin, sub_clk_pin;
  ctm_pins_t    pins;
  int           num_errors = 0;
  int           compares = 0;
  int           cycles = 0;

  always #4 clk = ~clk;

  ctm_top u_dut (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .ext_tick_pin(ext_tick_pin), .hi_clk_pin(hi_clk_pin), .sub_clk_pin(sub_clk_pin), .pins(pins));
  ctm_tick_src u_src (.clk(clk), .ext_tick_pin(ext_tick_pin), .hi_clk_pin(hi_clk_pin),
    .sub_clk_pin(sub_clk_pin));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask
  // Data is taken one clock after the strobe edge, its only valid cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic bad(input logic [31:0] got, input logic [31:0] exp);
    num_errors++;
    $display("ERROR at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) bad(32'(got), 32'(exp));
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) bad(32'(got), 32'(exp));
  endtask
  task automatic chk_range(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) bad(got, lo);
  endtask
  // High then low read back to back, so the captured byte is read at once
  task automatic rd_count(output int v);
    logic [7:0] h, l;
    @(posedge clk) bus_req <= '{addr: 4'h3, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus_req <= '{addr: 4'h2, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    #1 h = bus_rdata;
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 l = bus_rdata;
    v = {h[1:0], l};
  endtask
  task automatic wr_fine(input logic [9:0] v);
    wr(4'h4, v[7:0]);
    wr(4'h5, {6'h00, v[9:8]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    for (int a = 0; a < 9; a++) begin
      rd(4'(a), d);
      chk_byte(d, 8'h00);
    end
    wr(4'h3, 8'h03);
    wr(4'h2, 8'hff);
    rd(4'h3, d);
    chk_byte(d, 8'h00);
    wr_fine(10'h25a);
    rd(4'h5, d);
    chk_byte(d, 8'h02);
    rd(4'h4, d);
    chk_byte(d, 8'h5a);
    wr(4'h4, 8'h33);
    rd(4'h5, d);
    rd(4'h4, d);
    chk_byte(d, 8'h5a);
    $display("test regs done");
  endtask

  // Tick sources: internal counts after 256 clocks, bands allow for sync and phase; external counts exact after set pulses
  task automatic t_ticks();
    int lo[6] = '{60, 250, 1, 0, 8, 8};
    int hi[6] = '{65, 256, 3, 1, 12, 12};
    int v;
    for (int s = 0; s < 6; s++) begin
      wr(4'h0, 8'h00);
      wr(4'h0, {1'b0, 3'(s), 1'b1, 3'h0});
      repeat (256) @(posedge clk);
      rd_count(v);
      chk_range(v, lo[s], hi[s]);
    end
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h68);
    u_src.pulses(5);
    rd_count(v);
    chk_range(v, 5, 5);
    wr(4'h0, 8'h78);
    u_src.pulses(3);
    rd_count(v);
    chk_range(v, 8, 8);
    $display("test ticks done");
  endtask

  // Hold and stop both freeze the count; restart clears it
  task automatic t_hold();
    int v0, v1;
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h18);
    repeat (100) @(posedge clk);
    wr(4'h0, 8'h98);
    rd_count(v0);
    repeat (50) @(posedge clk);
    rd_count(v1);
    chk_range(v1, v0, v0);
    wr(4'h0, 8'h18);
    repeat (20) @(posedge clk);
    rd_count(v1);
    chk_range(v1, v0 + 20, v0 + 30);
    wr(4'h0, 8'h10);
    rd_count(v0);
    repeat (30) @(posedge clk);
    rd_count(v1);
    chk_range(v1, v0, v0);
    wr(4'h0, 8'h18);
    rd_count(v1);
    chk_range(v1, 0, 8);
    $display("test hold done");
  endtask

  // Compare mode: each action and start level, pin b inverted
  task automatic t_cmp();
    logic [7:0] d;
    logic       exp;
    int         v;
    wr(4'h7, 8'h02);
    wr_fine(10'h040);
    for (int k = 0; k < 8; k++) begin
      wr(4'h0, 8'h10);
      wr(4'h1, {2'b00, 2'(k % 4), 1'(k / 4), 3'h0});
      wr(4'h0, 8'h19);
      repeat (20) @(posedge clk);
      #1;
      chk_pin(pins.wave_out_a, 1'(k / 4));
      repeat (60) @(posedge clk);
      #1;
      exp = (k % 4 == 0) ? 1'(k / 4) : (k % 4 == 1) ? 1'b0 : (k % 4 == 2) ? 1'b1 : ~1'(k / 4);
      chk_pin(pins.wave_out_a, exp);
      chk_pin(pins.wave_out_b, ~exp);
    end
    for (int c = 0; c < 2; c++) begin
      wr(4'h0, 8'h10);
      wr(4'h1, 8'(1 - c));
      wr(4'h6, 8'h03);
      wr(4'h0, 8'h19);
      repeat (300) @(posedge clk);
      rd(4'h6, d);
      chk_byte(d, c ? 8'h03 : 8'h01);
      rd_count(v);
      chk_range(v, 0, c ? 127 : 63);
    end
    $display("test compare done");
  endtask

  // PWM: duty 32 of period 128, high clocks over four periods
  task automatic t_pwm();
    logic [7:0] cfg[6] = '{8'ha8, 8'h88, 8'h98, 8'hac, 8'haa, 8'he8};
    int         exp[6] = '{128, 0, 512, 384, 512, 0};
    int         n;
    wr(4'h7, 8'h00);
    wr_fine(10'h020);
    // Last entry is timer mode: the pin function stays idle there
    for (int k = 0; k < 6; k++) begin
      wr(4'h0, 8'h10);
      wr(4'h1, cfg[k]);
      wr(4'h0, 8'h19);
      repeat (256) @(posedge clk);
      n = 0;
      repeat (512) begin
        @(posedge clk);
        #1 n += (pins.wave_out_a === 1'b1);
      end
      chk_range(n, exp[k], exp[k]);
    end
    $display("test pwm done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cut a hang well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_ticks();
    t_hold();
    t_cmp();
    t_pwm();
    report_and_stop();
  end
endmodule // testbench
